// *** hw/pscr_cfg.svh ***
`ifndef PSCR_CFG_SVH
`define PSCR_CFG_SVH

// ==========================================================================
// Address map.
`define PSCR_REGION_BASE 32'hffd0_0000
`define PSCR_WIN_SHIFT 14
`define PSCR_WIN_IDX_W 8
`define PSCR_INTC_BASE 32'hffff_f000
`define PSCR_INTC_SHIFT 12
`define PSCR_BANK_BASE 32'hfffe_0000

// ==========================================================================
// Register layout inside the bank window.
`define PSCR_NUM_REGS 4
`define PSCR_IDX_LSB 4
`define PSCR_IDX_MSB 5
`define PSCR_ALIAS_LSB 2
`define PSCR_ALIAS_MSB 3
`define PSCR_PAD_LSB 6
`define PSCR_OFS_SET 2'h0
`define PSCR_OFS_CLR 2'h1
`define PSCR_OFS_VAL 2'h2
`define PSCR_REG_RESET 32'h0000_0000

`endif

// *** hw/pscr_pkg.sv ***
package pscr_pkg;

	typedef logic [31:0] pscr_word_t;

	typedef enum logic [1:0] {
		PSCR_ALIAS_SET,
		PSCR_ALIAS_CLR,
		PSCR_ALIAS_VAL,
		PSCR_ALIAS_NONE
	} pscr_alias_t;

endpackage

// *** hw/pscr_sc_word.sv ***
`timescale 1ns/100ps
`include "pscr_cfg.svh"

module pscr_sc_word (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic setEn,
	input wire logic clrEn,
	input wire pscr_pkg::pscr_word_t wrData,
	output pscr_pkg::pscr_word_t value
);
	import pscr_pkg::*;

	pscr_word_t value_q;
	pscr_word_t value_d;

	// ======================================================================
	// Storage.
	always_comb begin
		value_d = value_q;
		if (setEn) begin
			value_d = value_q | wrData;
		end else if (clrEn) begin
			value_d = value_q & ~wrData;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			value_q <= `PSCR_REG_RESET;
		end else begin
			value_q <= value_d;
		end
	end

	assign value = value_q;

	// ======================================================================
	// Checks.
	set_ones_a: assert property (@(posedge clk_sys) disable iff (rst)
		setEn |=> ((value_q & $past(wrData)) == $past(wrData)))
		else $error("Set alias failed to raise a written one.");

	clr_ones_a: assert property (@(posedge clk_sys) disable iff (rst)
		(clrEn && !setEn) |=> ((value_q & $past(wrData)) == 32'h0000_0000))
		else $error("Clear alias failed to drop a written one.");

	zero_keep_a: assert property (@(posedge clk_sys) disable iff (rst)
		(setEn || clrEn) |=> ((value_q & ~$past(wrData)) == ($past(value_q) & ~$past(wrData))))
		else $error("A bit written with zero changed.");

	idle_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
		(!setEn && !clrEn) |=> $stable(value_q))
		else $error("Word changed without a set or clear write.");

endmodule

// *** hw/pscr_regbank.sv ***
// Behaviour
// - A write to a register's set alias raises every bit written as one.
// - A write to a register's clear alias drops every bit written as one.
// - A read at the value alias returns the register's stored value.
// - Set and clear aliases change only bits written with one; no read-modify-write.
// - Bits written with zero at set or clear aliases keep their value.
// - Peripheral windows are 16 Kbyte, all within the top 3 Mbyte.
// - The interrupt controller window is 4 Kbyte instead.
// - Register offsets count upward from the window's lowest address, its base.
// - Data words travel little-endian: bit 0 sits in the lowest byte.

`timescale 1ns/100ps
`include "pscr_cfg.svh"

module pscr_regbank (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic busSel,
	input wire logic busWrite,
	input wire pscr_pkg::pscr_word_t busAddr,
	input wire pscr_pkg::pscr_word_t busWdata,
	output pscr_pkg::pscr_word_t busRdata,
	output logic busReady,
	output logic busError,
	output logic periphHit,
	output logic [`PSCR_WIN_IDX_W-1:0] periphIdx,
	output logic intcHit,
	output logic [`PSCR_NUM_REGS*32-1:0] regValue
);
	import pscr_pkg::*;

	localparam pscr_word_t RegionBase = `PSCR_REGION_BASE;
	localparam pscr_word_t IntcBase = `PSCR_INTC_BASE;
	localparam pscr_word_t BankBase = `PSCR_BANK_BASE;

	// ======================================================================
	// Address decode.
	pscr_word_t regionOfs;
	logic inRegion;
	logic intcMatch;
	logic bankMatch;
	logic mapped;
	logic [1:0] regIdx;
	pscr_alias_t aliasSel;
	pscr_word_t wordVal [`PSCR_NUM_REGS];

	always_comb begin
		regionOfs = busAddr - RegionBase;
		inRegion = (busAddr >= RegionBase);
		intcMatch = inRegion && (busAddr[31:`PSCR_INTC_SHIFT] == IntcBase[31:`PSCR_INTC_SHIFT]);
		bankMatch = inRegion && !intcMatch
			&& (busAddr[31:`PSCR_WIN_SHIFT] == BankBase[31:`PSCR_WIN_SHIFT]);
		regIdx = busAddr[`PSCR_IDX_MSB:`PSCR_IDX_LSB];
		unique case (busAddr[`PSCR_ALIAS_MSB:`PSCR_ALIAS_LSB])
			`PSCR_OFS_SET: aliasSel = PSCR_ALIAS_SET;
			`PSCR_OFS_CLR: aliasSel = PSCR_ALIAS_CLR;
			`PSCR_OFS_VAL: aliasSel = PSCR_ALIAS_VAL;
			default: aliasSel = PSCR_ALIAS_NONE;
		endcase
		// Misaligned or out-of-layout offsets inside the window are flagged, not silently aliased.
		mapped = bankMatch && (busAddr[`PSCR_WIN_SHIFT-1:`PSCR_PAD_LSB] == '0)
			&& (busAddr[1:0] == 2'h0) && (aliasSel != PSCR_ALIAS_NONE);
	end

	// ======================================================================
	// Register words.
	genvar gi;
	generate
		for (gi = 0; gi < `PSCR_NUM_REGS; gi++) begin : gWord
			logic setEn;
			logic clrEn;
			assign setEn = busSel && busWrite && mapped && (regIdx == 2'(gi)) && (aliasSel == PSCR_ALIAS_SET);
			assign clrEn = busSel && busWrite && mapped && (regIdx == 2'(gi)) && (aliasSel == PSCR_ALIAS_CLR);
			pscr_sc_word uWord (
				.clk_sys(clk_sys),
				.rst(rst),
				.setEn(setEn),
				.clrEn(clrEn),
				.wrData(busWdata),
				.value(wordVal[gi])
			);
			assign regValue[gi*32 +: 32] = wordVal[gi];
		end
	endgenerate

	// ======================================================================
	// Bus answer and decoder outputs.
	pscr_word_t rdata_q;
	pscr_word_t rdata_d;
	logic ready_q;
	logic ready_d;
	logic error_q;
	logic error_d;
	logic periphHit_q;
	logic periphHit_d;
	logic [`PSCR_WIN_IDX_W-1:0] periphIdx_q;
	logic [`PSCR_WIN_IDX_W-1:0] periphIdx_d;
	logic intcHit_q;
	logic intcHit_d;

	always_comb begin
		rdata_d = '0;
		ready_d = busSel && bankMatch;
		error_d = busSel && bankMatch && !mapped;
		// Bytes keep their lanes: byte 0 of the word is bits 7:0, with no swapping.
		if (busSel && !busWrite && mapped && (aliasSel == PSCR_ALIAS_VAL)) begin
			rdata_d = wordVal[regIdx];
		end
		periphHit_d = busSel && inRegion && !intcMatch;
		periphIdx_d = regionOfs[`PSCR_WIN_SHIFT +: `PSCR_WIN_IDX_W];
		intcHit_d = busSel && intcMatch;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rdata_q <= '0;
			ready_q <= 1'b0;
			error_q <= 1'b0;
			periphHit_q <= 1'b0;
			periphIdx_q <= '0;
			intcHit_q <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			ready_q <= ready_d;
			error_q <= error_d;
			periphHit_q <= periphHit_d;
			periphIdx_q <= periphIdx_d;
			intcHit_q <= intcHit_d;
		end
	end

	assign busRdata = rdata_q;
	assign busReady = ready_q;
	assign busError = error_q;
	assign periphHit = periphHit_q;
	assign periphIdx = periphIdx_q;
	assign intcHit = intcHit_q;

	// ======================================================================
	// Checks.
	val_read_a: assert property (@(posedge clk_sys) disable iff (rst)
		(busSel && !busWrite && mapped && aliasSel == PSCR_ALIAS_VAL)
		|=> (busReady && busRdata == $past(wordVal[regIdx])))
		else $error("Value alias read returned wrong data.");

	set_write_a: assert property (@(posedge clk_sys) disable iff (rst)
		(busSel && busWrite && mapped && aliasSel == PSCR_ALIAS_SET && regIdx == 2'h0)
		|=> (regValue[31:0] == ($past(regValue[31:0]) | $past(busWdata))))
		else $error("Set alias write did not OR into register zero.");

	clr_write_a: assert property (@(posedge clk_sys) disable iff (rst)
		(busSel && busWrite && mapped && aliasSel == PSCR_ALIAS_CLR && regIdx == 2'h1)
		|=> (regValue[63:32] == ($past(regValue[63:32]) & ~$past(busWdata))))
		else $error("Clear alias write did not mask register one.");

	val_write_a: assert property (@(posedge clk_sys) disable iff (rst)
		(busSel && busWrite && aliasSel == PSCR_ALIAS_VAL) |=> $stable(regValue))
		else $error("Write to value alias changed a register.");

	win_index_a: assert property (@(posedge clk_sys) disable iff (rst)
		(busSel && busAddr >= RegionBase && !intcMatch)
		|=> (periphHit && periphIdx == 8'(($past(busAddr) - RegionBase) >> 14)))
		else $error("Peripheral window index wrong.");

	intc_window_a: assert property (@(posedge clk_sys) disable iff (rst)
		(busSel && busAddr[31:12] == 20'hfffff) |=> (intcHit && !periphHit))
		else $error("Interrupt controller window not decoded.");

	bank_base_a: assert property (@(posedge clk_sys) disable iff (rst)
		(busSel && !busWrite && busAddr == BankBase + 32'h0000_0008)
		|=> (busReady && !busError && busRdata == $past(regValue[31:0])))
		else $error("Register zero not at base plus value offset.");

	misalign_a: assert property (@(posedge clk_sys) disable iff (rst)
		(busSel && bankMatch && busAddr[1:0] != 2'h0)
		|=> (busReady && busError) ##1 (busReady == $past(busSel && bankMatch)))
		else $error("Misaligned access not answered with a one-cycle error.");

	// A refused access must leave every word alone, so software can probe the map without side effects.
	refuse_keep_a: assert property (@(posedge clk_sys) disable iff (rst)
		(busSel && busWrite && bankMatch && !mapped)
		|=> $stable(regValue))
		else $error("Refused write changed a register.");

	other_keep_a: assert property (@(posedge clk_sys) disable iff (rst)
		(busSel && busWrite && mapped && regIdx == 2'h0)
		|=> $stable(regValue[127:32]))
		else $error("Write to register zero touched another register.");

	set_three_a: assert property (@(posedge clk_sys) disable iff (rst)
		(busSel && busWrite && mapped && aliasSel == PSCR_ALIAS_SET && regIdx == 2'h3)
		|=> (regValue[127:96] == ($past(regValue[127:96]) | $past(busWdata))))
		else $error("Set alias write did not OR into register three.");

	clr_two_a: assert property (@(posedge clk_sys) disable iff (rst)
		(busSel && busWrite && mapped && aliasSel == PSCR_ALIAS_CLR && regIdx == 2'h2)
		|=> (regValue[95:64] == ($past(regValue[95:64]) & ~$past(busWdata))))
		else $error("Clear alias write did not mask register two.");

	rdata_idle_a: assert property (@(posedge clk_sys) disable iff (rst)
		!(busSel && !busWrite && mapped && aliasSel == PSCR_ALIAS_VAL)
		|=> (busRdata == 32'h0000_0000))
		else $error("Read data not zero outside a value read.");

	byte_lane_a: assert property (@(posedge clk_sys) disable iff (rst)
		(busSel && !busWrite && mapped && aliasSel == PSCR_ALIAS_VAL && regIdx == 2'h1)
		|=> (busRdata[7:0] == $past(regValue[39:32])))
		else $error("Lowest byte of a read left its lane.");

	ready_pulse_a: assert property (@(posedge clk_sys) disable iff (rst)
		!(busSel && bankMatch) |=> !busReady)
		else $error("Answer without an access to the bank.");

	error_ready_a: assert property (@(posedge clk_sys) disable iff (rst)
		busError |-> busReady)
		else $error("Error raised without an answer.");

	outside_quiet_a: assert property (@(posedge clk_sys) disable iff (rst)
		(busSel && !inRegion) |=> (!periphHit && !intcHit && !busReady))
		else $error("Access below the peripheral region was decoded.");

	intc_edge_a: assert property (@(posedge clk_sys) disable iff (rst)
		(busSel && busAddr[31:12] == 20'hffffe) |=> (periphHit && !intcHit && periphIdx == 8'hbf))
		else $error("Interrupt controller window reaches below its own 4 Kbyte.");

endmodule

// *** sim/pscr_host.sv ***
`timescale 1ns/100ps
// ====
// Bus master standing in for the processor side.
module pscr_host (
	input wire logic clk_sys,
	output logic busSel,
	output logic busWrite,
	output pscr_pkg::pscr_word_t busAddr,
	output pscr_pkg::pscr_word_t busWdata
);
	import pscr_pkg::*;
	initial begin
		busSel = 1'b0;
		busWrite = 1'b0;
		busAddr = 32'h0;
		busWdata = 32'h0;
	end
	// Idle lines are inverted, so a stale value can never pass for a fresh one.
	task automatic access(input logic w, input pscr_word_t a, input pscr_word_t d);
		@(posedge clk_sys);
		busSel <= 1'b1;
		busWrite <= w;
		busAddr <= a;
		busWdata <= d;
		@(posedge clk_sys);
		busSel <= 1'b0;
		busWrite <= ~w;
		busAddr <= ~a;
		busWdata <= ~d;
		@(negedge clk_sys);
	endtask
endmodule

// *** sim/periph_set_clear_regbank_test.sv ***
`timescale 1ns/100ps
`include "pscr_cfg.svh"
module periph_set_clear_regbank_test;
	import pscr_pkg::*;
	localparam logic [7:0] bankIdx = 8'((`PSCR_BANK_BASE - `PSCR_REGION_BASE) >> `PSCR_WIN_SHIFT);
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic busSel, busWrite, busReady, busError, periphHit, intcHit, inR, ic;
	pscr_word_t busAddr, busWdata, busRdata, r, d, a;
	logic [7:0] periphIdx;
	logic [127:0] regValue;
	logic [31:0] m [4];
	logic [31:0] seed = 32'hfb76;
	logic [31:0] badOfs [3] = '{32'hc, 32'h1, 32'h40};
	logic [31:0] winAddr [5] = '{32'hffd0_0000, 32'hffd0_4000, 32'hffff_e000, 32'hffff_f000, 32'hffcf_c000};
	int bad_count = 0;
	int total_checks = 0;
	always #10 clk_sys = ~clk_sys;
	pscr_host i_host (.clk_sys(clk_sys), .busSel(busSel), .busWrite(busWrite), .busAddr(busAddr), .busWdata(busWdata));
	pscr_regbank i_dut (.clk_sys(clk_sys), .rst(rst), .busSel(busSel), .busWrite(busWrite), .busAddr(busAddr),
		.busWdata(busWdata), .busRdata(busRdata), .busReady(busReady), .busError(busError),
		.periphHit(periphHit), .periphIdx(periphIdx), .intcHit(intcHit), .regValue(regValue));
	// ====
	// Helpers.
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// The window index only means something while the peripheral hit flag is up.
	task automatic chkAnswer(input logic [3:0] f, input logic [7:0] idx);
		chk({busReady, busError, periphHit, intcHit, f[1] ? periphIdx : 8'h0}, {f, f[1] ? idx : 8'h0});
	endtask
	task automatic chkRegs();
		for (int i = 0; i < 4; i++) begin
			chk(regValue[32*i+:32], m[i]);
		end
	endtask
	task automatic final_report();
		$display("checks=%0d bad=%0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// ====
	// Sequence.
	initial begin
		for (int i = 0; i < 4; i++) m[i] = 32'h0;
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		chkRegs();
		for (int n = 0; n < 60; n++) begin
			r = rnd();
			d = rnd();
			a = `PSCR_BANK_BASE + {r[1:0], 4'h0} + {r[2], 2'h0};
			i_host.access(1'b1, a, d);
			m[r[1:0]] = r[2] ? m[r[1:0]] & ~d : m[r[1:0]] | d;
			chkAnswer(4'ha, bankIdx);
			chkRegs();
			i_host.access(1'b0, (a & ~32'h4) | 32'h8, rnd());
			chk(busRdata, m[r[1:0]]);
		end
		foreach (badOfs[k]) begin
			i_host.access(1'b1, `PSCR_BANK_BASE + badOfs[k], 32'hffff_ffff);
			chkAnswer(4'he, bankIdx);
			chkRegs();
		end
		i_host.access(1'b1, `PSCR_BANK_BASE + 32'h8, 32'hffff_ffff);
		chkAnswer(4'ha, bankIdx);
		chkRegs();
		foreach (winAddr[k]) begin
			a = winAddr[k];
			inR = a >= `PSCR_REGION_BASE;
			ic = a >= `PSCR_INTC_BASE;
			i_host.access(1'b0, a, 32'h0);
			chkAnswer({2'h0, inR && !ic, ic}, 8'((a - `PSCR_REGION_BASE) >> `PSCR_WIN_SHIFT));
		end
		@(posedge clk_sys);
		rst <= 1'b1;
		@(posedge clk_sys);
		rst <= 1'b0;
		for (int i = 0; i < 4; i++) m[i] = 32'h0;
		chkRegs();
		final_report();
	end
	// About two cycles per access; the limit leaves ample room.
	initial begin
		#(4000 * 20);
		bad_count++;
		final_report();
	end
endmodule
